// ==== src/dcdi_core.v ====
// Command block of an attached disk: door unlock, microcode download,
// self-diagnostic with the partner device, and identification readout.
// Assumes an APB master on the register side and an open-drain PDIAG- line.
`timescale 1ns/1ps
`include "dcdi_regs.vh"

module dcdi_core #(
    parameter DIAG_RUN_CYC = 64,
    parameter [27:0] WAIT0_CYC = `DCDI_T_DEV0_WAIT_MS * `DCDI_CLK_KHZ,
    parameter [27:0] DONE1_CYC = `DCDI_T_DEV1_DONE_MS * `DCDI_CLK_KHZ
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg intrq,
    input wire pdiag_n,
    output reg pdiag_n_drv,
    output reg pdiag_n_oe,
    input wire dev1_detect,
    input wire mcr_button,
    input wire selftest_fail,
    input wire [6:0] selftest_code
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DIAG_RUN = 3'd1;
    localparam [2:0] ST_DIAG_WAIT = 3'd2;
    localparam [2:0] ST_ID_PREP = 3'd3;
    localparam [2:0] ST_ID_XFER = 3'd4;
    localparam [2:0] ST_MC_XFER = 3'd5;
    localparam [31:0] RUN_CYC_FULL = DIAG_RUN_CYC;
    localparam [27:0] RUN_CYC = RUN_CYC_FULL[27:0];

    reg [2:0] state_reg;
    reg [7:0] feat_reg;
    reg [7:0] scnt_reg;
    reg [7:0] snum_reg;
    reg [7:0] cyll_reg;
    reg [7:0] cylh_reg;
    reg [7:0] dh_reg;
    reg [7:0] err_reg;
    reg [7:0] cfg_reg;
    reg bsy_reg;
    reg drdy_reg;
    reg drq_reg;
    reg errst_reg;
    reg locked_reg;
    reg present_reg;
    reg capture_reg;
    reg [27:0] timer_reg;
    reg [23:0] wcnt_reg;
    reg [7:0] idx_reg;
    reg [7:0] idx_next;
    wire [15:0] id_word;

    wire setup = psel & ~penable;
    wire xfer_done = psel & penable & pready;
    wire wr = xfer_done & pwrite;
    wire rd = xfer_done & ~pwrite;
    wire [7:0] status = {bsy_reg, drdy_reg, 2'b00, drq_reg, 2'b00, errst_reg};
    wire role_dev1 = cfg_reg[`DCDI_CFG_DEV1];
    wire dev_ready = cfg_reg[`DCDI_CFG_READY];
    wire selected = (dh_reg[`DCDI_DH_DEV] == role_dev1);
    wire [6:0] own_code = ~selftest_fail ? `DCDI_DIAG_PASS :
        ((selftest_code == `DCDI_DIAG_PASS) ? `DCDI_DIAG_FAIL : selftest_code);
    wire cmd_wr = wr & (paddr == `DCDI_OFF_CMDSTAT) & ~bsy_reg;
    wire reg_wr = wr & ~bsy_reg;
    wire data_pop = rd & (paddr == `DCDI_OFF_DATA) & (state_reg == ST_ID_XFER);
    wire data_push = wr & (paddr == `DCDI_OFF_DATA) & (state_reg == ST_MC_XFER);
    wire status_rd = rd & (paddr == `DCDI_OFF_CMDSTAT);

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a[1:0] == 2'b00) && (a <= `DCDI_OFF_INFO);
        end
    endfunction

    function [31:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `DCDI_OFF_DATA: read_mux = {16'h0000, id_word};
                `DCDI_OFF_ERRFEAT: read_mux = {24'h00_0000, err_reg};
                `DCDI_OFF_SCNT: read_mux = {24'h00_0000, scnt_reg};
                `DCDI_OFF_SNUM: read_mux = {24'h00_0000, snum_reg};
                `DCDI_OFF_CYLL: read_mux = {24'h00_0000, cyll_reg};
                `DCDI_OFF_CYLH: read_mux = {24'h00_0000, cylh_reg};
                `DCDI_OFF_DH: read_mux = {24'h00_0000, dh_reg};
                `DCDI_OFF_CMDSTAT: read_mux = {24'h00_0000, status};
                `DCDI_OFF_CFG: read_mux = {24'h00_0000, cfg_reg};
                `DCDI_OFF_INFO: read_mux = {26'h000_0000, state_reg, mcr_button & ~locked_reg,
                    present_reg, locked_reg};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Identification store
    // ----------------------------------------
    // ascending word order
    always @* begin
        idx_next = idx_reg;
        if (cmd_wr) begin
            idx_next = 8'h00;
        end else if (data_pop) begin
            idx_next = idx_reg + 8'h01;
        end
    end

    dcdi_id_rom u_rom (
        .clk(clk),
        .ce(ce),
        .addr(idx_next),
        .removable(cfg_reg[`DCDI_CFG_REMOV]),
        .atapi(cfg_reg[`DCDI_CFG_ATAPI]),
        .q(id_word)
    );

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (setup) begin
                pready <= 1'b1;
                pslverr <= ~is_mapped(paddr);
                prdata <= pwrite ? 32'h0000_0000 : read_mux(paddr);
            end else if (xfer_done) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Command engine
    // ----------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            feat_reg <= `DCDI_REG_ZERO;
            scnt_reg <= `DCDI_REG_ONE;
            snum_reg <= `DCDI_REG_ONE;
            cyll_reg <= `DCDI_REG_ZERO;
            cylh_reg <= `DCDI_REG_ZERO;
            dh_reg <= `DCDI_REG_ZERO;
            err_reg <= `DCDI_REG_ONE;
            cfg_reg <= `DCDI_CFG_RESET;
            bsy_reg <= 1'b0;
            drdy_reg <= 1'b1;
            drq_reg <= 1'b0;
            errst_reg <= 1'b0;
            locked_reg <= 1'b0;
            present_reg <= 1'b0;
            capture_reg <= 1'b1;
            timer_reg <= 28'h000_0000;
            wcnt_reg <= 24'h00_0000;
            idx_reg <= 8'h00;
            intrq <= 1'b0;
            pdiag_n_drv <= 1'b0;
            pdiag_n_oe <= 1'b0;
        end else if (ce) begin
            idx_reg <= idx_next;
            if (capture_reg) begin
                capture_reg <= 1'b0;
                present_reg <= dev1_detect;
            end
            if (status_rd | cmd_wr) begin
                intrq <= 1'b0;
            end
            if (reg_wr) begin
                case (paddr)
                    `DCDI_OFF_ERRFEAT: feat_reg <= pwdata[7:0];
                    `DCDI_OFF_SCNT: scnt_reg <= pwdata[7:0];
                    `DCDI_OFF_SNUM: snum_reg <= pwdata[7:0];
                    `DCDI_OFF_CYLL: cyll_reg <= pwdata[7:0];
                    `DCDI_OFF_CYLH: cylh_reg <= pwdata[7:0];
                    `DCDI_OFF_DH: dh_reg <= pwdata[7:0];
                    `DCDI_OFF_CFG: cfg_reg <= pwdata[7:0];
                    default: ;
                endcase
            end
            case (state_reg)
                ST_IDLE: begin
                    timer_reg <= 28'h000_0000;
                    if (cmd_wr & (selected | (pwdata[7:0] == `DCDI_OP_DIAG))) begin
                        errst_reg <= 1'b0;
                        err_reg <= `DCDI_REG_ZERO;
                        case (pwdata[7:0])
                            `DCDI_OP_DIAG: begin
                                bsy_reg <= 1'b1;
                                drdy_reg <= 1'b0;
                                pdiag_n_oe <= 1'b0;
                                state_reg <= ST_DIAG_RUN;
                            end
                            `DCDI_OP_IDENT: begin
                                bsy_reg <= 1'b1;
                                state_reg <= ST_ID_PREP;
                            end
                            `DCDI_OP_MCODE: begin
                                if (~cfg_reg[`DCDI_CFG_MCSUP] |
                                    ((feat_reg != `DCDI_MC_TEMP) &
                                     (feat_reg != `DCDI_MC_SAVE))) begin
                                    err_reg[`DCDI_ER_ABRT] <= 1'b1;
                                    errst_reg <= 1'b1;
                                    intrq <= 1'b1;
                                end else if ({snum_reg, scnt_reg} == 16'h0000) begin
                                    intrq <= 1'b1;
                                end else begin
                                    wcnt_reg <= {snum_reg, scnt_reg, 8'h00};
                                    drq_reg <= 1'b1;
                                    state_reg <= ST_MC_XFER;
                                end
                            end
                            `DCDI_OP_UNLOCK, `DCDI_OP_EJECT: begin
                                if (~cfg_reg[`DCDI_CFG_DOOR] | ~dev_ready) begin
                                    err_reg[`DCDI_ER_ABRT] <= 1'b1;
                                    errst_reg <= 1'b1;
                                end else begin
                                    locked_reg <= 1'b0;
                                end
                                intrq <= 1'b1;
                            end
                            `DCDI_OP_LOCK: begin
                                if (~cfg_reg[`DCDI_CFG_DOOR] | ~dev_ready) begin
                                    err_reg[`DCDI_ER_ABRT] <= 1'b1;
                                    errst_reg <= 1'b1;
                                end else if (locked_reg & mcr_button) begin
                                    err_reg[`DCDI_ER_MCR] <= 1'b1;
                                    errst_reg <= 1'b1;
                                end else begin
                                    locked_reg <= 1'b1;
                                end
                                intrq <= 1'b1;
                            end
                            default: begin
                                err_reg[`DCDI_ER_ABRT] <= 1'b1;
                                errst_reg <= 1'b1;
                                intrq <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_DIAG_RUN: begin
                    timer_reg <= timer_reg + 28'h000_0001;
                    if ((timer_reg >= RUN_CYC - 28'h000_0001) |
                        (timer_reg >= DONE1_CYC - 28'h000_0002)) begin
                        cyll_reg <= `DCDI_REG_ZERO;
                        cylh_reg <= `DCDI_REG_ZERO;
                        dh_reg <= `DCDI_REG_ZERO;
                        scnt_reg <= `DCDI_REG_ONE;
                        snum_reg <= `DCDI_REG_ONE;
                        err_reg <= {1'b0, own_code};
                        if (role_dev1) begin
                            pdiag_n_oe <= ~selftest_fail;
                            bsy_reg <= 1'b0;
                            drdy_reg <= 1'b1;
                            intrq <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg <= ST_DIAG_WAIT;
                        end
                    end
                end
                ST_DIAG_WAIT: begin
                    timer_reg <= timer_reg + 28'h000_0001;
                    if (~present_reg | ~pdiag_n) begin
                        bsy_reg <= 1'b0;
                        drdy_reg <= 1'b1;
                        intrq <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (timer_reg >= WAIT0_CYC - 28'h000_0002) begin
                        err_reg[7] <= 1'b1;
                        bsy_reg <= 1'b0;
                        drdy_reg <= 1'b1;
                        intrq <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ID_PREP: begin
                    drq_reg <= 1'b1;
                    bsy_reg <= 1'b0;
                    intrq <= 1'b1;
                    state_reg <= ST_ID_XFER;
                end
                ST_ID_XFER: begin
                    if (data_pop & (idx_reg == `DCDI_ID_LAST)) begin
                        drq_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_MC_XFER: begin
                    if (data_push) begin
                        wcnt_reg <= wcnt_reg - 24'h00_0001;
                        if (wcnt_reg == 24'h00_0001) begin
                            drq_reg <= 1'b0;
                            intrq <= 1'b1;
                            state_reg <= ST_IDLE;
                            if (~cfg_reg[`DCDI_CFG_MCACC]) begin
                                err_reg[`DCDI_ER_ABRT] <= 1'b1;
                                errst_reg <= 1'b1;
                            end
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule // dcdi_core

// ==== src/dcdi_regs.vh ====
// Constants of the disk command block: register offsets, bit fields,
// opcodes and timing figures. Assumes a 32-bit APB slave with byte offsets.
`ifndef DCDI_REGS_VH
`define DCDI_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCDI_OFF_DATA 8'h00
`define DCDI_OFF_ERRFEAT 8'h04
`define DCDI_OFF_SCNT 8'h08
`define DCDI_OFF_SNUM 8'h0C
`define DCDI_OFF_CYLL 8'h10
`define DCDI_OFF_CYLH 8'h14
`define DCDI_OFF_DH 8'h18
`define DCDI_OFF_CMDSTAT 8'h1C
`define DCDI_OFF_CFG 8'h20
`define DCDI_OFF_INFO 8'h24

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define DCDI_ST_BSY 7
`define DCDI_ST_DRDY 6
`define DCDI_ST_DRQ 3
`define DCDI_ST_ERR 0
`define DCDI_ER_MCR 3
`define DCDI_ER_ABRT 2
`define DCDI_DH_DEV 4
`define DCDI_CFG_DEV1 0
`define DCDI_CFG_DOOR 1
`define DCDI_CFG_READY 2
`define DCDI_CFG_MCSUP 3
`define DCDI_CFG_MCACC 4
`define DCDI_CFG_REMOV 5
`define DCDI_CFG_ATAPI 6
`define DCDI_CFG_RESET 8'h2E
`define DCDI_DIAG_PASS 7'h01
`define DCDI_DIAG_FAIL 7'h00
`define DCDI_REG_ZERO 8'h00
`define DCDI_REG_ONE 8'h01

// ----------------------------------------
// Opcodes and subcommands
// ----------------------------------------
`define DCDI_OP_LOCK 8'hDE
`define DCDI_OP_UNLOCK 8'hDF
`define DCDI_OP_EJECT 8'hED
`define DCDI_OP_MCODE 8'h92
`define DCDI_OP_DIAG 8'h90
`define DCDI_OP_IDENT 8'hEC
`define DCDI_MC_TEMP 8'h01
`define DCDI_MC_SAVE 8'h07
`define DCDI_ID_LAST 8'hFF
`define DCDI_WORDS_PER_SECTOR 256

// ----------------------------------------
// Timing
// ----------------------------------------
`define DCDI_CLK_KHZ 25000
`define DCDI_T_BSY_SET_NS 400
`define DCDI_T_PDIAG_REL_MS 1
`define DCDI_T_DEV1_DONE_MS 5000
`define DCDI_T_DEV0_WAIT_MS 6000

`endif

// ==== src/dcdi_id_rom.v ====
// Identification block store: 256 words, read data registered.
// Assumes the caller presents the address one cycle before it wants the word.
`timescale 1ns/1ps

module dcdi_id_rom #(
    parameter [319:0] MODEL = "GENERIC DISK MODEL                      ",
    parameter [159:0] SERIAL = "0000000000000000001 ",
    parameter [63:0] FIRMWARE = "REV 1.0 ",
    parameter [15:0] CYLS = 16'h0400,
    parameter [15:0] HEADS = 16'h0010,
    parameter [15:0] SECTS = 16'h003F,
    parameter [31:0] CAPACITY = 32'h000F_C000
) (
    input wire clk,
    input wire ce,
    input wire [7:0] addr,
    input wire removable,
    input wire atapi,
    output reg [15:0] q
);

    reg [15:0] word;
    integer k;

    // Reserved words and bits fall through to zero; text puts the first
    // character of each pair in the upper byte; 32-bit values send low half first.
    always @* begin
        k = addr;
        word = 16'h0000;
        case (1'b1)
            (k == 0): word = {atapi, 7'h00, removable, ~removable, 6'h00};
            (k == 1): word = CYLS;
            (k == 3): word = HEADS;
            (k == 6): word = SECTS;
            (k >= 10 && k <= 19): word = SERIAL[159 - 16 * (k - 10) -: 16];
            (k >= 23 && k <= 26): word = FIRMWARE[63 - 16 * (k - 23) -: 16];
            (k >= 27 && k <= 46): word = MODEL[319 - 16 * (k - 27) -: 16];
            (k == 49): word = 16'h0200;
            (k == 57 || k == 60): word = CAPACITY[15:0];
            (k == 58 || k == 61): word = CAPACITY[31:16];
            default: word = 16'h0000;
        endcase
    end

    always @(posedge clk) begin
        if (ce) begin
            q <= word;
        end
    end

endmodule // dcdi_id_rom

// ==== sim/dcdi_partner.sv ====
// Second device on the shared PDIAG- line, diagnostic side only.
// Assumes the bench pulses trig in the cycle the diagnostic command lands.
`timescale 1ns/1ps

module dcdi_partner #(
    parameter DELAY_CYC = 20
) (
    input wire clk,
    input wire trig,
    input wire pass,
    output reg pull_low
);
    integer cnt = -1;
    initial pull_low = 1'b0;
    always @(posedge clk) begin
        if (trig) begin
            pull_low <= 1'b0;
            cnt <= DELAY_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            pull_low <= pass;
            cnt <= -1;
        end
    end
endmodule // dcdi_partner

// ==== sim/dcdi_core_monitor.sv ====
// Checker for the disk command block: APB answer, PDIAG- drive, diagnostic timing.
// Assumes ce is held high and the host never writes a command while busy.
`timescale 1ns/1ps

module dcdi_core_monitor #(
    parameter DIAG_RUN_CYC = 64
) (
    input wire clk,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire intrq,
    input wire pdiag_n_drv,
    input wire pdiag_n_oe
);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_diag_wr;
        psel && penable && pready && pwrite && paddr == 8'h1C && pwdata[7:0] == 8'h90;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_ready_next: assert property (s_setup |=> pready && psel && penable)
        else $error("access phase not answered");
    a_ready_once: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready outside one access cycle");
    a_unmapped_err: assert property (pready && (paddr > 8'h24 || paddr[1:0] != 2'b00)
        |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
    a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_open_drain: assert property (pdiag_n_oe |-> pdiag_n_drv == 1'b0)
        else $error("diagnostic line driven high");
    a_diag_release: assert property (s_diag_wr |=> !pdiag_n_oe)
        else $error("diagnostic line not released");
    a_diag_busy: assert property (s_diag_wr |=> !intrq [*3])
        else $error("diagnostic completed too early");
    a_diag_done: assert property (s_diag_wr |-> ##[1:300] intrq)
        else $error("diagnostic did not complete");
    a_reset_idle: assert property ($fell(srst) |-> !pready && !intrq && !pdiag_n_oe)
        else $error("outputs active after reset");
endmodule // dcdi_core_monitor

bind dcdi_core dcdi_core_monitor #(.DIAG_RUN_CYC(DIAG_RUN_CYC)) i_dcdi_core_monitor (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intrq(intrq), .pdiag_n_drv(pdiag_n_drv), .pdiag_n_oe(pdiag_n_oe));

// ==== sim/dcdi_core_test.sv ====
// Bench for the disk command block: APB tasks and command sequences.
// Assumes the core, its identify store and the partner model are compiled.
`timescale 1ns/1ps

module dcdi_core_test;
    reg clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg trig = 1'b0, pass = 1'b0, fail = 1'b0, se;
    reg ce = 1'b1, dev1 = 1'b0, btn = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0000_0000, rd;
    wire [31:0] prdata;
    wire pready, pslverr, intrq, oe, low, drv;
    wire pdiag_n = ~low & (oe ? drv : 1'b1);
    integer n_fail = 0, checked = 0, i, k;
    always #20 clk = ~clk;

    dcdi_core #(.DIAG_RUN_CYC(4), .WAIT0_CYC(28'h00C8), .DONE1_CYC(28'h0064)) i_dcdi_core (
        .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .intrq(intrq), .pdiag_n(pdiag_n), .pdiag_n_drv(drv), .pdiag_n_oe(oe), .dev1_detect(dev1),
        .mcr_button(btn), .selftest_fail(fail), .selftest_code(7'h05));
    dcdi_partner i_dcdi_partner (.clk(clk), .trig(trig), .pass(pass), .pull_low(low));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task tally_and_finish;
        begin
            if (n_fail == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            if (pready !== 1'b1) begin
                n_fail = n_fail + 1;
                tally_and_finish;
            end
            rd = prdata;
            se = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdc(input string what, input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0000_0000);
            chk(what, rd & m, e);
        end
    endtask
    task idle;
        integer n;
        begin
            n = 0;
            do begin
                xfer(1'b0, 8'h1C, 32'h0000_0000);
                n = n + 1;
            end while (rd[7] !== 1'b0 && n < 400);
            if (rd[7] !== 1'b0) begin
                n_fail = n_fail + 1;
                tally_and_finish;
            end
        end
    endtask
    task cmd(input [7:0] op);
        begin
            xfer(1'b1, 8'h1C, {24'h00_0000, op});
            idle;
        end
    endtask
    task diag;
        begin
            xfer(1'b1, 8'h1C, 32'h0000_0090);
            trig <= 1'b1;
            @(posedge clk);
            trig <= 1'b0;
            rdc("diag busy", 8'h1C, 32'hC0, 32'h80);
            idle;
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rdc("reset status", 8'h1C, 32'hC9, 32'h40);
        rdc("reset error", 8'h04, 32'hFF, 32'h01);
        xfer(1'b0, 8'h28, 32'h0000_0000);
        chk("unmapped", se, 1);
        diag;
        rdc("no partner", 8'h04, 32'hFF, 32'h01);
        xfer(1'b1, 8'h1C, 32'h0000_00EC);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        chk("frozen irq", intrq, 0);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk("identify irq", intrq, 1);
        idle;
        chk("identify drq", rd & 32'h89, 32'h08);
        for (i = 0; i < 256; i = i + 1) begin
            xfer(1'b0, 8'h00, 32'h0000_0000);
            if (i == 0) chk("word 0", rd, 32'h0080);
            if (i == 2) chk("word 2", rd, 32'h0000);
            if (i == 27) chk("word 27", rd, 32'h4745);
            if (i == 60) chk("word 60", rd, 32'hC000);
            if (i == 61) chk("word 61", rd, 32'h000F);
        end
        rdc("identify end", 8'h1C, 32'h08, 32'h00);
        cmd(8'hDE);
        rdc("locked", 8'h24, 32'h01, 32'h01);
        btn <= 1'b1;
        cmd(8'hDE);
        chk("lock button", rd & 32'h01, 32'h01);
        rdc("media change", 8'h04, 32'h08, 32'h08);
        rdc("button masked", 8'h24, 32'h04, 32'h00);
        cmd(8'hDF);
        chk("unlock status", rd & 32'h01, 32'h00);
        rdc("unlocked", 8'h24, 32'h05, 32'h04);
        btn <= 1'b0;
        xfer(1'b1, 8'h20, 32'h0000_002A);
        cmd(8'hDF);
        rdc("not ready abort", 8'h04, 32'h04, 32'h04);
        xfer(1'b1, 8'h20, 32'h0000_003E);
        xfer(1'b1, 8'h08, 32'h0000_0001);
        xfer(1'b1, 8'h0C, 32'h0000_0000);
        xfer(1'b1, 8'h10, 32'h0000_0000);
        xfer(1'b1, 8'h14, 32'h0000_0000);
        xfer(1'b1, 8'h04, 32'h0000_0005);
        cmd(8'h92);
        chk("reserved sub", rd & 32'h09, 32'h01);
        xfer(1'b1, 8'h04, 32'h0000_0001);
        cmd(8'h92);
        for (i = 0; i < 256; i = i + 1) begin
            if (i == 255) rdc("one left", 8'h1C, 32'h08, 32'h08);
            xfer(1'b1, 8'h00, 32'h0000_A5A5);
        end
        rdc("sector done", 8'h1C, 32'h09, 32'h00);
        xfer(1'b1, 8'h08, 32'h0000_0000);
        xfer(1'b1, 8'h04, 32'h0000_0007);
        cmd(8'h92);
        chk("zero length", rd & 32'h09, 32'h00);
        xfer(1'b1, 8'h0C, 32'h0000_0001);
        cmd(8'h92);
        chk("upper length", rd & 32'h09, 32'h08);
        @(posedge clk);
        dev1 <= 1'b1;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rdc("reset again", 8'h1C, 32'hC9, 32'h40);
        rdc("partner seen", 8'h24, 32'h02, 32'h02);
        xfer(1'b1, 8'h18, 32'h0000_0010);
        for (k = 0; k < 2; k = k + 1) begin
            pass <= (k == 0);
            diag;
            rdc("dev0 code", 8'h04, 32'hFF, k ? 32'h81 : 32'h01);
            for (i = 0; i < 5; i = i + 1)
                rdc("diag regs", 8'h08 + 4 * i, 32'hFF, i < 2 ? 32'h01 : 32'h00);
        end
        xfer(1'b1, 8'h20, 32'h0000_002F);
        for (k = 0; k < 2; k = k + 1) begin
            fail <= (k == 1);
            diag;
            chk("dev1 line", oe, k == 0);
            rdc("dev1 code", 8'h04, 32'hFF, k ? 32'h05 : 32'h01);
        end
        tally_and_finish;
    end
endmodule // dcdi_core_test
